// file: rtl/scan_bridge.sv
// Addressable multidrop scan bridge with three local scan ports
//
// Overview of operation
// R1 - Master walks all bridges to Shift-IR, shifts slot address, Update-IR.
// R2 - At Update-IR a matching slot address selects; others become unselected.
// R3 - Capture-IR loads 01 low and the six slot bits above.
// R4 - Master reads an all-ones capture as an empty slot.
// R5 - Return-to-wait sends every selection controller to Wait-For-Address.
// R6 - Return-to-wait also resets the local scan ports that are not idle-parked.
// R7 - Port-config-select scans the mode register; 00000111 chains all ports.
// R8 - Mode register survives deselection; only Test-Logic-Reset clears it.
// R9 - Activate unparks moded ports, joining once bridge is in step.
// R10 - Park-in-reset holds all local mode selects high.
// R11 - Park-in-idle parks ports in Run-Test/Idle, keeping local instructions.
// R12 - Group-register-select scans the two-bit multicast group register.
// R13 - A multicast address matching the group selects as multicast.
// R14 - Compactor-enable starts compaction in every selected bridge.
// R15 - Compactor-select scans the signature out; it survives deselection.
// R16 - Broadcast address 3B hex selects every bridge.
// R17 - Local-reset drives all local mode selects high.
// R18 - Unselected bridges keep backplane output off and ignore instructions other than return-to-wait.
`include "scan_bridge_consts.svh"
module scan_bridge (
   input wire logic clk,
   input wire logic reset_n,
   input wire scan_bridge_pkg::bp_in_t backplane,
   input wire logic [5:0] slot_id_inputs,
   input wire logic [`NUM_PORTS-1:0] local_tdo,
   output logic tdo_b,
   output logic tdo_b_oe_n,
   output scan_bridge_pkg::local_pins_t local_out,
   output logic bridge_selected
);
   import scan_bridge_pkg::*;

   // ==================================================
   // Reset release and pin synchronisers
   logic [1:0] rst_q;
   logic rst_n;
   logic [11:0] sync1, sync2;
   logic tck_d;
   logic tck_s, tms_s, tdi_s, tck_rise, tck_fall;
   logic [`NUM_PORTS-1:0] ltdo_s;
   logic [5:0] slot_s;

   // Deassertion is synchronised, assertion is immediate
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rst_q <= 2'b00;
      end else begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];

   // All pins are asynchronous to clk, so two stages each
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync1 <= 12'h000;
         sync2 <= 12'h000;
         tck_d <= 1'b0;
      end else begin
         sync1 <= {backplane, local_tdo, slot_id_inputs};
         sync2 <= sync1;
         tck_d <= sync2[11];
      end
   end
   assign tck_s = sync2[11];
   assign tms_s = sync2[10];
   assign tdi_s = sync2[9];
   assign ltdo_s = sync2[8:6];
   assign slot_s = sync2[5:0];
   assign tck_rise = tck_s & ~tck_d;
   assign tck_fall = ~tck_s & tck_d;

   // ==================================================
   // Bridge test access port
   tap_state_t tap;

   tap_ctrl u_tap (
      .clk(clk),
      .rst_n(rst_n),
      .step(tck_rise),
      .tms(tms_s),
      .state(tap)
   );

   // ==================================================
   // Helpers
   // Scan a bit in at the top of the register the instruction picks
   function automatic logic [`DR_W-1:0] dr_shift(logic [`DR_W-1:0] d,
         logic [`IR_W-1:0] ins, logic b);
      logic [`DR_W-1:0] r;
      r = d >> 1;
      case (ins)
         `OP_PORT_CFG: r[`MODE_W-1] = b;
         `OP_GROUP_SEL: r[`GROUP_W-1] = b;
         `OP_COMP_SEL: r[`SIG_W-1] = b;
         default: r[0] = b;
      endcase
      return r;
   endfunction

   // Signature compactor step, data folded into the feedback
   function automatic logic [`SIG_W-1:0] lfsr_step(logic [`SIG_W-1:0] s,
         logic b);
      logic fb;
      fb = s[`SIG_W-1] ^ b;
      return {s[`SIG_W-2:0], 1'b0} ^ (fb ? `SIG_POLY : `SIG_RESET);
   endfunction

   // ==================================================
   // Core state
   logic [`IR_W-1:0] ir, next_ir, instr, next_instr;
   sel_state_t sel, next_sel;
   logic [`MODE_W-1:0] mode, next_mode;
   logic [`GROUP_W-1:0] group, next_group;
   logic [`SIG_W-1:0] sig, next_sig;
   logic [`DR_W-1:0] dr, next_dr;
   logic comp_en, next_comp_en;
   port_state_t port [`NUM_PORTS];
   port_state_t next_port [`NUM_PORTS];
   logic is_sel;
   logic [`NUM_PORTS-1:0] feed;
   logic chain_out;

   assign is_sel = (sel == SEL_SINGLE) || (sel == SEL_MULTI) ||
      (sel == SEL_BCAST);

   // Serial path: backplane data through active local chains in order
   always_comb begin
      chain_out = tdi_s;
      for (int i = 0; i < `NUM_PORTS; i++) begin
         feed[i] = chain_out;
         if (port[i] == PORT_ACTIVE) begin
            chain_out = ltdo_s[i];
         end
      end
   end

   // Next values of instruction, selection, data registers and ports
   always_comb begin
      next_ir = ir;
      next_instr = instr;
      next_sel = sel;
      next_mode = mode;
      next_group = group;
      next_sig = sig;
      next_dr = dr;
      next_comp_en = comp_en;
      next_port = port;
      if (tap == TAP_TLR) begin
         // Test-Logic-Reset clears every register; return-to-wait also clears selection, instruction and non-idle ports
         next_ir = `OP_BYPASS;
         next_instr = `OP_BYPASS;
         next_sel = SEL_WAIT;
         next_mode = `MODE_RESET; // R8
         next_group = `GROUP_RESET;
         next_sig = `SIG_RESET;
         next_dr = {`DR_W{1'b0}};
         next_comp_en = 1'b0;
         for (int i = 0; i < `NUM_PORTS; i++) next_port[i] = PORT_RESET;
      end else if (tck_rise) begin
         case (tap)
            TAP_CAP_IR: next_ir = {slot_s, `CAPTURE_LOW}; // R3
            TAP_SH_IR: next_ir = {chain_out, ir[`IR_W-1:1]};
            TAP_UPD_IR: begin
               if (ir == `OP_RETURN_TO_WAIT) begin
                  next_sel = SEL_WAIT; // R5
                  next_instr = `OP_BYPASS;
                  // Idle-parked ports keep their local instruction in force
                  for (int i = 0; i < `NUM_PORTS; i++) begin
                     if (port[i] != PORT_IDLE) begin // R11
                        next_port[i] = PORT_RESET; // R6
                     end
                  end
               end else if (sel == SEL_WAIT) begin
                  // Address decode; a slot match beats the group codes
                  if (ir == {2'b00, slot_s}) begin
                     next_sel = SEL_SINGLE; // R2
                  end else if (ir == `BCAST_ADDR) begin
                     next_sel = SEL_BCAST; // R16
                  end else if (ir[`IR_W-1:2] == `MCAST_PREFIX &&
                        ir[1:0] == group) begin
                     next_sel = SEL_MULTI; // R13
                  end else begin
                     next_sel = SEL_UNSEL; // R2
                  end
               end else if (is_sel) begin
                  // Unselected bridges fall through and ignore it
                  next_instr = ir; // R18
                  case (ir)
                     `OP_ACTIVATE: begin
                        for (int i = 0; i < `NUM_PORTS; i++) begin
                           if (mode[i] && port[i] != PORT_ACTIVE) begin
                              next_port[i] = PORT_PENDING; // R9
                           end
                        end
                     end
                     `OP_PARK_RESET, `OP_LOCAL_RESET: begin
                        for (int i = 0; i < `NUM_PORTS; i++) begin
                           next_port[i] = PORT_RESET; // R10 R17
                        end
                     end
                     `OP_PARK_IDLE: begin
                        for (int i = 0; i < `NUM_PORTS; i++) begin
                           if (port[i] == PORT_ACTIVE) begin
                              next_port[i] = PORT_IDLE; // R11
                           end
                        end
                     end
                     `OP_COMP_EN: next_comp_en = 1'b1; // R14
                     default: ;
                  endcase
               end
            end
            TAP_CAP_DR: begin
               case (instr)
                  `OP_PORT_CFG: next_dr = {8'h00, mode}; // R7
                  `OP_GROUP_SEL: next_dr = {14'h0000, group}; // R12
                  `OP_COMP_SEL: next_dr = sig; // R15
                  default: next_dr = {`DR_W{1'b0}};
               endcase
            end
            TAP_SH_DR: begin
               next_dr = dr_shift(dr, instr, chain_out);
               // Compaction pauses while the signature is read out
               if (comp_en && is_sel && instr != `OP_COMP_SEL) begin
                  next_sig = lfsr_step(sig, tdi_s); // R14
               end
            end
            TAP_UPD_DR: begin
               if (is_sel && instr == `OP_PORT_CFG) begin
                  next_mode = dr[`MODE_W-1:0]; // R7
               end
               if (is_sel && instr == `OP_GROUP_SEL) begin
                  next_group = dr[`GROUP_W-1:0]; // R12
               end
            end
            TAP_RTI: begin
               // Locals are in Run-Test/Idle too, so they move in step
               for (int i = 0; i < `NUM_PORTS; i++) begin
                  if (port[i] == PORT_PENDING) begin
                     next_port[i] = PORT_ACTIVE; // R9
                  end
               end
            end
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ir <= `OP_BYPASS;
         instr <= `OP_BYPASS;
         sel <= SEL_WAIT;
         mode <= `MODE_RESET;
         group <= `GROUP_RESET;
         sig <= `SIG_RESET;
         dr <= {`DR_W{1'b0}};
         comp_en <= 1'b0;
         for (int i = 0; i < `NUM_PORTS; i++) port[i] <= PORT_RESET;
      end else begin
         ir <= next_ir;
         instr <= next_instr;
         sel <= next_sel;
         mode <= next_mode;
         group <= next_group;
         sig <= next_sig;
         dr <= next_dr;
         comp_en <= next_comp_en;
         port <= next_port;
      end
   end

   // ==================================================
   // Pin outputs
   logic next_tdo, next_oe_n, next_selected;
   local_pins_t next_local;

   // Data changes on the falling test clock, as the standard expects
   always_comb begin
      next_tdo = tdo_b;
      next_oe_n = tdo_b_oe_n;
      next_local.tck = tck_s;
      next_local.tdi = local_out.tdi;
      next_selected = is_sel;
      for (int i = 0; i < `NUM_PORTS; i++) begin
         case (port[i])
            PORT_RESET: next_local.tms[i] = 1'b1; // R10 R17
            PORT_ACTIVE: next_local.tms[i] = tms_s;
            default: next_local.tms[i] = 1'b0; // R11
         endcase
      end
      if (tck_fall) begin
         next_tdo = (tap == TAP_SH_IR) ? ir[0] : dr[0];
         // Group selections stay quiet to avoid bus contention
         next_oe_n = !(sel == SEL_SINGLE &&
            (tap == TAP_SH_IR || tap == TAP_SH_DR)); // R18
         next_local.tdi = feed;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tdo_b <= 1'b1;
         tdo_b_oe_n <= 1'b1;
         local_out <= {1'b0, 3'b111, 3'b111};
         bridge_selected <= 1'b0;
      end else begin
         tdo_b <= next_tdo;
         tdo_b_oe_n <= next_oe_n;
         local_out <= next_local;
         bridge_selected <= next_selected;
      end
   end

   // ==================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence ir_update_s;
      tck_rise && tap == TAP_UPD_IR;
   endsequence
   sequence dr_update_s;
      tck_rise && tap == TAP_UPD_DR;
   endsequence

   a_capture_ir_pattern: assert property ( // R3
      tck_rise && tap == TAP_CAP_IR |=> ir == {$past(slot_s), 2'b01})
      else $error("capture-IR pattern wrong");
   a_slot_match_select: assert property ( // R2
      ir_update_s ##0 (sel == SEL_WAIT && ir == {2'b00, slot_s} &&
      ir != `OP_RETURN_TO_WAIT) |=> sel == SEL_SINGLE)
      else $error("slot match did not select");
   a_return_wait: assert property ( // R5 R6
      ir_update_s ##0 ir == `OP_RETURN_TO_WAIT |=> sel == SEL_WAIT &&
      port[0] inside {PORT_RESET, PORT_IDLE} &&
      port[1] inside {PORT_RESET, PORT_IDLE} &&
      port[2] inside {PORT_RESET, PORT_IDLE})
      else $error("return-to-wait not honoured");
   a_idle_kept: assert property ( // R11
      ir_update_s ##0 (ir == `OP_RETURN_TO_WAIT && port[0] == PORT_IDLE) |=>
      port[0] == PORT_IDLE)
      else $error("idle-parked port lost on return-to-wait");
   a_bcast_select: assert property ( // R16
      ir_update_s ##0 (sel == SEL_WAIT && ir == `BCAST_ADDR &&
      slot_s != 6'h3b) |=> sel == SEL_BCAST)
      else $error("broadcast did not select");
   a_mcast_select: assert property ( // R13
      ir_update_s ##0 (sel == SEL_WAIT && ir == {`MCAST_PREFIX, group} &&
      ir != {2'b00, slot_s}) |=> sel == SEL_MULTI)
      else $error("multicast did not select");
   a_mode_load: assert property ( // R7
      dr_update_s ##0 (is_sel && instr == `OP_PORT_CFG) |=>
      mode == $past(dr[7:0]))
      else $error("mode register not loaded");
   a_mode_hold: assert property ( // R8
      tap != TAP_TLR && !(tck_rise && tap == TAP_UPD_DR) |=> $stable(mode))
      else $error("mode register changed");
   a_group_load: assert property ( // R12
      dr_update_s ##0 (is_sel && instr == `OP_GROUP_SEL) |=>
      group == $past(dr[1:0]))
      else $error("group register not loaded");
   a_comp_enable: assert property ( // R14
      ir_update_s ##0 (is_sel && ir == `OP_COMP_EN) |=> comp_en)
      else $error("compactor not enabled");
   a_sig_hold: assert property ( // R15
      tap != TAP_TLR && !(tck_rise && tap == TAP_SH_DR) |=> $stable(sig))
      else $error("signature changed");
   a_port_join: assert property ( // R9
      tck_rise && tap == TAP_RTI && port[0] == PORT_PENDING |=>
      port[0] == PORT_ACTIVE)
      else $error("pending port did not join");
   a_reset_park_high: assert property ( // R10
      ir_update_s ##0 (is_sel && ir == `OP_PARK_RESET) |=> ##1
      local_out.tms == 3'b111)
      else $error("park-in-reset left a select low");
   a_soft_reset: assert property ( // R17
      ir_update_s ##0 (is_sel && ir == `OP_LOCAL_RESET) |=> ##1
      local_out.tms == 3'b111 [*3])
      else $error("local reset not held high");
   a_idle_park_low: assert property ( // R11
      port[0] == PORT_IDLE |=> !local_out.tms[0])
      else $error("idle-parked port select high");
   a_tdo_quiet: assert property ( // R18
      $fell(tdo_b_oe_n) |-> $past(sel) == SEL_SINGLE)
      else $error("unselected bridge drove data out");
endmodule

// file: rtl/scan_bridge_consts.svh
// Constants for the addressable scan bridge
`ifndef SCAN_BRIDGE_CONSTS_SVH
`define SCAN_BRIDGE_CONSTS_SVH
`define NUM_PORTS 3
`define IR_W 8
`define MODE_W 8
`define GROUP_W 2
`define SIG_W 16
`define DR_W 16
`define CAPTURE_LOW 2'b01
`define BCAST_ADDR 8'h3b
`define MCAST_PREFIX 6'h0f
`define OP_RETURN_TO_WAIT 8'h80
`define OP_PORT_CFG 8'h81
`define OP_GROUP_SEL 8'h82
`define OP_ACTIVATE 8'h83
`define OP_PARK_RESET 8'h84
`define OP_PARK_IDLE 8'h85
`define OP_COMP_EN 8'h86
`define OP_COMP_SEL 8'h87
`define OP_LOCAL_RESET 8'h88
`define OP_BYPASS 8'hff
`define MODE_RESET 8'h00
`define GROUP_RESET 2'h0
`define SIG_RESET 16'h0000
`define SIG_POLY 16'h100b
`endif

// file: rtl/scan_bridge_pkg.sv
// Types shared by the scan bridge modules
`include "scan_bridge_consts.svh"
package scan_bridge_pkg;
   typedef enum logic [3:0] {
      TAP_TLR, TAP_RTI, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
      TAP_PA_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
      TAP_SH_IR, TAP_EX1_IR, TAP_PA_IR, TAP_EX2_IR, TAP_UPD_IR
   } tap_state_t;
   typedef enum logic [2:0] {
      SEL_WAIT, SEL_SINGLE, SEL_MULTI, SEL_BCAST, SEL_UNSEL
   } sel_state_t;
   typedef enum logic [1:0] {
      PORT_RESET, PORT_IDLE, PORT_PENDING, PORT_ACTIVE
   } port_state_t;
   // Backplane test pins seen by the bridge
   typedef struct packed {
      logic tck;
      logic tms;
      logic tdi;
   } bp_in_t;
   // Pins driven toward the three local scan ports
   typedef struct packed {
      logic tck;
      logic [`NUM_PORTS-1:0] tms;
      logic [`NUM_PORTS-1:0] tdi;
   } local_pins_t;
endpackage

// file: rtl/tap_ctrl.sv
// Test access port state machine, stepped on sampled test clock edges
`include "scan_bridge_consts.svh"
module tap_ctrl (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic step,
   input wire logic tms,
   output scan_bridge_pkg::tap_state_t state
);
   import scan_bridge_pkg::*;

   tap_state_t next_state;

   // ==================================================
   // Next state, advanced only on a test clock rise
   always_comb begin
      next_state = state;
      if (step) begin
         case (state)
            TAP_TLR: next_state = tms ? TAP_TLR : TAP_RTI;
            TAP_RTI: next_state = tms ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_DR: next_state = tms ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: next_state = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR: next_state = tms ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: next_state = tms ? TAP_UPD_DR : TAP_PA_DR;
            TAP_PA_DR: next_state = tms ? TAP_EX2_DR : TAP_PA_DR;
            TAP_EX2_DR: next_state = tms ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: next_state = tms ? TAP_SEL_DR : TAP_RTI;
            TAP_SEL_IR: next_state = tms ? TAP_TLR : TAP_CAP_IR;
            TAP_CAP_IR: next_state = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR: next_state = tms ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: next_state = tms ? TAP_UPD_IR : TAP_PA_IR;
            TAP_PA_IR: next_state = tms ? TAP_EX2_IR : TAP_PA_IR;
            TAP_EX2_IR: next_state = tms ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: next_state = tms ? TAP_SEL_DR : TAP_RTI;
            default: next_state = TAP_TLR;
         endcase
      end
   end

   // State register, starts in Test-Logic-Reset
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= TAP_TLR;
      end else begin
         state <= next_state;
      end
   end
endmodule

// file: dv/backplane_master.sv
// Behavioural backplane test master for the scan bridge
module backplane_master (
   input wire logic clk,
   input wire logic tdo_b,
   input wire logic tdo_b_oe_n,
   output scan_bridge_pkg::bp_in_t bp
);
   timeunit 1ns;
   timeprecision 1ns;
   import scan_bridge_pkg::*;

   // Test clock starts low and rests high between frames
   initial bp = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};

   // ==========================================================
   // One test clock period: 5 clk low, 3 clk high (800 ns)
   task automatic tick(input logic tms, input logic tdi, output logic seen);
      @(posedge clk);
      bp.tck <= 1'b0;
      bp.tms <= tms;
      bp.tdi <= tdi;
      repeat (5) @(posedge clk);
      // Released line reads high through the bus pull-up
      seen = tdo_b_oe_n ? 1'b1 : tdo_b;
      bp.tck <= 1'b1;
      repeat (2) @(posedge clk);
   endtask

   // Mode select high for five periods, then settle in idle
   task automatic reset_tap();
      logic b;
      repeat (5) tick(1'b1, 1'b0, b);
      tick(1'b0, 1'b0, b);
   endtask

   // Extra periods in Run-Test/Idle
   task automatic idle(input int n);
      logic b;
      repeat (n) tick(1'b0, 1'b0, b);
   endtask

   // ==========================================================
   // Full scan from idle to idle, LSB first; ir picks the IR path
   task automatic scan(input logic ir, input int n, input logic [15:0] din,
                       output logic [15:0] dout);
      logic b;
      dout = '0;
      tick(1'b1, 1'b0, b);
      if (ir) tick(1'b1, 1'b0, b);
      tick(1'b0, 1'b0, b);
      tick(1'b0, 1'b0, b);
      for (int i = 0; i < n; i++) begin
         tick(i == n - 1, din[i], b);
         dout[i] = b;
      end
      tick(1'b1, 1'b0, b);
      tick(1'b0, 1'b0, b);
      // Let the synchronised update reach the outputs
      repeat (4) @(posedge clk);
   endtask
endmodule

// file: dv/multidrop_scan_bridge_control_test.sv
// Self-checking bench for the addressable scan bridge
`include "scan_bridge_consts.svh"
module multidrop_scan_bridge_control_test;
   timeunit 1ns;
   timeprecision 1ns;
   import scan_bridge_pkg::*;
   localparam logic [5:0] SLOT = 6'h05;
   logic clk;
   logic reset_n;
   logic [5:0] slot_id_inputs;
   logic [`NUM_PORTS-1:0] local_tdo;
   logic tdo_b;
   logic tdo_b_oe_n;
   logic bridge_selected;
   bp_in_t backplane;
   local_pins_t local_out;
   logic [15:0] dout;
   int num_errors = 0;
   int checked = 0;
   int cycles = 0;
   // Each active loopback chain after the first holds back one bit
   int chain_extra = 0;

   scan_bridge i_dut (.clk(clk), .reset_n(reset_n), .backplane(backplane),
      .slot_id_inputs(slot_id_inputs), .local_tdo(local_tdo),
      .tdo_b(tdo_b), .tdo_b_oe_n(tdo_b_oe_n), .local_out(local_out),
      .bridge_selected(bridge_selected));

   backplane_master i_master (.clk(clk), .tdo_b(tdo_b),
      .tdo_b_oe_n(tdo_b_oe_n), .bp(backplane));

   // Local chains of zero length: data returns as sent
   assign local_tdo = local_out.tdi;

   // ==========================================================
   // Clock and hang guard
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end

   // ==========================================================
   // Shared helpers
   task automatic check(input string name, input logic [15:0] seen,
                        input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic ir(input logic [7:0] op);
      i_master.scan(1'b1, 8 + chain_extra, {8'h00, op}, dout);
   endtask

   task automatic dr(input int n, input logic [15:0] d);
      i_master.scan(1'b0, n, d, dout);
   endtask

   // Signature after folding four serial bits into a cleared register
   function automatic logic [15:0] fold(input logic [3:0] bits);
      logic [15:0] sig;
      sig = `SIG_RESET;
      for (int i = 0; i < 4; i++) begin
         sig = {sig[14:0], 1'b0} ^ ((sig[15] ^ bits[i]) ? `SIG_POLY : 16'h0);
      end
      return sig;
   endfunction

   // ==========================================================
   // Scenarios
   task automatic t_poll();
      ir({2'b00, SLOT});
      check("selected", bridge_selected, 1'b1);
      ir(`OP_RETURN_TO_WAIT);
      check("capture", dout[7:0], {SLOT, `CAPTURE_LOW});
      check("waiting", bridge_selected, 1'b0);
   endtask

   // A foreign address must leave the bridge off the shared bus
   task automatic t_miss();
      ir({2'b00, SLOT ^ 6'h01});
      check("foreign", bridge_selected, 1'b0);
      ir(`OP_PORT_CFG);
      check("no drive", dout[7:0], 8'hff);
      ir(`OP_RETURN_TO_WAIT);
   endtask

   task automatic t_mode();
      ir({2'b00, SLOT});
      ir(`OP_PORT_CFG);
      dr(8, 16'h0007);
      ir(`OP_ACTIVATE);
      i_master.idle(2);
      check("unparked", local_out.tms, 3'b000);
      chain_extra = 2;
      ir(`OP_RETURN_TO_WAIT);
      chain_extra = 0;
      check("wait resets", local_out.tms, 3'b111);
      ir({2'b00, SLOT});
      ir(`OP_PORT_CFG);
      dr(8, 16'h0007);
      check("mode kept", dout[7:0], 8'h07);
      ir(`OP_ACTIVATE);
      i_master.idle(2);
      chain_extra = 2;
      ir(`OP_PARK_IDLE);
      chain_extra = 0;
      ir(`OP_RETURN_TO_WAIT);
      check("deselected", bridge_selected, 1'b0);
      check("idle parked", local_out.tms, 3'b000);
      ir({2'b00, SLOT});
      ir(`OP_PARK_RESET);
      check("reset parked", local_out.tms, 3'b111);
      ir(`OP_RETURN_TO_WAIT);
   endtask

   // Group setup, multicast compaction, later readout alone
   task automatic t_group();
      ir({2'b00, SLOT});
      ir(`OP_GROUP_SEL);
      dr(2, 16'h0001);
      ir(`OP_RETURN_TO_WAIT);
      ir({`MCAST_PREFIX, 2'b01});
      check("multicast", bridge_selected, 1'b1);
      ir(`OP_COMP_EN);
      check("group silent", dout[7:0], 8'hff);
      dr(4, 16'h000b);
      ir(`OP_RETURN_TO_WAIT);
      ir({2'b00, SLOT});
      ir(`OP_COMP_SEL);
      dr(16, 16'h0000);
      check("signature", dout, fold(4'hb));
      ir(`OP_RETURN_TO_WAIT);
   endtask

   // Broadcast, soft reset of local ports, then loss of mode in TLR
   task automatic t_bcast();
      ir(`BCAST_ADDR);
      check("broadcast", bridge_selected, 1'b1);
      ir(`OP_ACTIVATE);
      i_master.idle(2);
      chain_extra = 2;
      ir(`OP_LOCAL_RESET);
      chain_extra = 0;
      check("soft reset", local_out.tms, 3'b111);
      ir(`OP_RETURN_TO_WAIT);
      i_master.reset_tap();
      ir({2'b00, SLOT});
      ir(`OP_PORT_CFG);
      dr(8, 16'h0000);
      check("mode cleared", dout[7:0], `MODE_RESET);
      ir(`OP_RETURN_TO_WAIT);
   endtask

   // ==========================================================
   // Closing report
   task automatic report_and_stop();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      reset_n = 1'b0;
      slot_id_inputs = SLOT;
      repeat (20) @(posedge clk);
      reset_n <= 1'b1;
      repeat (5) @(posedge clk);
      i_master.reset_tap();
      t_poll();
      t_miss();
      t_mode();
      t_group();
      t_bcast();
      report_and_stop();
   end
endmodule
